// File: verilog/scan_gateway_map.vh
`ifndef SCAN_GATEWAY_MAP_VH
`define SCAN_GATEWAY_MAP_VH

// Shadow frame layout: sync marker, address, position, port configuration.
`define SYNC_W           8
`define SYNC_PATTERN     8'ha5
`define ADDR_W           10
`define POS_W            3
`define CFG_W            3
`define FRAME_W          24
// Acknowledge pattern shifted out on the primary data output, LSB first.
`define ACK_BITS         8
`define ACK_PATTERN      8'h3c
`define ACK_CNT_W        4
// Address that every gateway accepts as a broadcast.
`define BCAST_ADDR       10'h000
// Port configuration value that requests all ports off (active low selects).
`define CFG_ALL_OFF      3'h7

// Connect status codes.
`define ST_OFF           3'h0
`define ST_ON            3'h1
`define ST_BROADCAST     3'h2
`define ST_BYPASS        3'h3
`define ST_BYPASS_RESET  3'h4
`define ST_TEST_RESET    3'h5

// Wishbone register byte offsets.
`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_FRAMES       4'h8
// Control register fields and reset value.
`define CTRL_PROTO_EN    0
`define CTRL_DISCONNECT  1
`define CTRL_RESET       1'h1

`endif

// File: verilog/tap_state_tracker.v
`timescale 1ns/10ps
// Follows the standard test-port controller from sampled mode-select bits.
module tap_state_tracker (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       step,
    input  wire       tms,
    output reg  [3:0] state_q,
    output wire       stable
);
    localparam [3:0] TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
                     SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
                     UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
                     EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf;

    reg [3:0] state_d;

    // Shadow frames are only heard in four of the states that hold still: reset, idle and the two pause states.
    assign stable = (state_q == TLR) || (state_q == RTI) ||
                    (state_q == PA_DR) || (state_q == PA_IR);

    ////////////////////////////////////////////////////////////////////////
    // Next-state decode of the controller graph.
    always @* begin
        case (state_q)
            TLR:     state_d = tms ? TLR : RTI;
            RTI:     state_d = tms ? SEL_DR : RTI;
            SEL_DR:  state_d = tms ? SEL_IR : CAP_DR;
            CAP_DR:  state_d = tms ? EX1_DR : SH_DR;
            SH_DR:   state_d = tms ? EX1_DR : SH_DR;
            EX1_DR:  state_d = tms ? UPD_DR : PA_DR;
            PA_DR:   state_d = tms ? EX2_DR : PA_DR;
            EX2_DR:  state_d = tms ? UPD_DR : SH_DR;
            UPD_DR:  state_d = tms ? SEL_DR : RTI;
            SEL_IR:  state_d = tms ? TLR : CAP_IR;
            CAP_IR:  state_d = tms ? EX1_IR : SH_IR;
            SH_IR:   state_d = tms ? EX1_IR : SH_IR;
            EX1_IR:  state_d = tms ? UPD_IR : PA_IR;
            PA_IR:   state_d = tms ? EX2_IR : PA_IR;
            EX2_IR:  state_d = tms ? UPD_IR : SH_IR;
            UPD_IR:  state_d = tms ? SEL_DR : RTI;
            default: state_d = TLR;
        endcase
    end

    // Advance once per rising test-clock edge.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= TLR;
        end else if (step) begin
            state_q <= state_d;
        end
    end
endmodule // tap_state_tracker

// File: verilog/shadow_receiver.v
`timescale 1ns/10ps
`include "scan_gateway_map.vh"
// Serial shadow frame receiver; reports a frame when the sync marker lines up.
module shadow_receiver #(
    parameter FRAME_W = `FRAME_W
) (
    input  wire                clk_sys,
    input  wire                rst_n,
    input  wire                bit_stb,
    input  wire                bit_val,
    input  wire                enable,
    output reg                 frame_stb_q,
    output wire [`ADDR_W-1:0]  rx_addr,
    output wire [`POS_W-1:0]   rx_pos,
    output wire [`CFG_W-1:0]   rx_cfg
);
    reg [FRAME_W-1:0] shift_q;
    reg [5:0]         fill_q;
    wire              full;

    assign full    = (fill_q >= FRAME_W[5:0] - 6'h01);
    assign rx_addr = shift_q[`ADDR_W+`POS_W+`CFG_W-1:`POS_W+`CFG_W];
    assign rx_pos  = shift_q[`POS_W+`CFG_W-1:`CFG_W];
    assign rx_cfg  = shift_q[`CFG_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Bits enter MSB first; leaving a quiet state drops a partial frame so
    // ordinary scan data can never be taken for a frame.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_q     <= {FRAME_W{1'b0}};
            fill_q      <= 6'h00;
            frame_stb_q <= 1'b0;
        end else begin
            frame_stb_q <= 1'b0;
            if (!enable) begin
                fill_q <= 6'h00;
            end else if (bit_stb) begin
                shift_q <= {shift_q[FRAME_W-2:0], bit_val};
                if (full && shift_q[FRAME_W-2:FRAME_W-`SYNC_W-1] == `SYNC_PATTERN) begin
                    frame_stb_q <= 1'b1;
                    fill_q      <= 6'h00;
                end else if (!full) begin
                    fill_q <= fill_q + 6'h01;
                end
            end
        end
    end
endmodule // shadow_receiver

// File: verilog/scan_gateway.v
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "scan_gateway_map.vh"
// Summary of operation
// - Received address compared to straps, top bit MSB.
// - Received position compared to straps, MSB first.
// - Unconnected straps read as high.
// - Bypass low gives bypass or bypass-with-reset.
// - Bypass low ignores frames; bypass pins configure.
// - Bypass high lets frames be answered.
// - Active ports drive their connect indicator low.
// - Inactive ports hold their connect indicator high.
// - Indicators and primary output change on falling edges.
// - Test clock always forwarded to all ports.
// - Frames and status changes follow test clock.
// - Frame bits sampled on rising test clock.
// - Acknowledge first, connect only afterwards.
// - Active statuses route primary input to selected ports.
// - Acknowledge leaves on the primary data output.
// - Bypass and on statuses drive primary output.
// - Off, broadcast and test-reset statuses float primary output.
// - Track test-port states; frames only when stable.
// - Test reset low clears state asynchronously.
module scan_gateway (
    input  wire        clk_sys,
    input  wire        rstn,
    input  wire [9:0]  strap_address_inputs,
    input  wire [2:0]  strap_position_inputs,
    input  wire [5:0]  bypass_select_inputs,
    input  wire        primary_test_clock,
    input  wire        primary_data_in,
    input  wire        primary_mode_select,
    input  wire        primary_test_reset_n,
    input  wire [2:0]  secondary_data_ins,
    output reg  [2:0]  connect_indicators_n,
    output reg         primary_data_out,
    output reg         primary_data_out_oe,
    output reg  [2:0]  secondary_test_clocks,
    output reg  [2:0]  secondary_data_outs,
    output reg  [2:0]  secondary_data_outs_oe,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Stage one is read only by stage two.
    // Pads are assumed to carry pull-ups, so floating straps arrive as ones.
    // Two stages guard against metastability.
    // A false fall after reset is harmless.
    localparam PIN_W = 26;
    wire [PIN_W-1:0] pins_raw;
    reg  [PIN_W-1:0] pins_s1_q;
    reg  [PIN_W-1:0] pins_s2_q;
    reg              tck_prev_q;

    assign pins_raw = {strap_address_inputs, strap_position_inputs, bypass_select_inputs,
                       primary_test_clock, primary_data_in, primary_mode_select,
                       primary_test_reset_n, secondary_data_ins};

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pins_s1_q  <= {PIN_W{1'b1}};
            pins_s2_q  <= {PIN_W{1'b1}};
            tck_prev_q <= 1'b1;
        end else begin
            pins_s1_q  <= pins_raw;
            pins_s2_q  <= pins_s1_q;
            tck_prev_q <= pins_s2_q[6];
        end
    end

    // Named slices of the synchronised pins.
    wire [9:0] addr_s  = pins_s2_q[25:16];
    wire [2:0] pos_s   = pins_s2_q[15:13];
    wire [5:0] byp_s   = pins_s2_q[12:7];
    wire       tck_s   = pins_s2_q[6];
    wire       tdi_s   = pins_s2_q[5];
    wire       tms_s   = pins_s2_q[4];
    wire       trst_n_s = pins_s2_q[3];
    wire [2:0] sdi_s   = pins_s2_q[2:0];
    wire       tck_rise = tck_s & ~tck_prev_q;
    wire       tck_fall = ~tck_s & tck_prev_q;

    // Gateway state falls back to power-up whenever test reset is low.
    wire gw_rst_n = rstn & primary_test_reset_n;

    ////////////////////////////////////////////////////////////////////////
    // Register file and its control bits.
    reg        proto_en_q;
    reg        disconnect_q;
    reg [7:0]  frames_q;
    reg [2:0]  status_q;
    reg [2:0]  sel_n_q;
    reg [2:0]  status_eff;
    reg [2:0]  sel_eff;
    wire [3:0] tap_state;
    wire       tap_stable;

    // Only byte lane 0 gates writes.
    wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr   = wb_req & wb_we_i & wb_sel_i[0];

    // Every cycle request gets a one-cycle ack on the next edge, mapped or not.
    // Unmapped offsets still answer.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h00000000;
            proto_en_q   <= `CTRL_RESET;
            disconnect_q <= 1'b0;
        end else begin
            wb_ack_o     <= wb_req;
            disconnect_q <= 1'b0;
            if (wb_wr && wb_adr_i == `REG_CTRL) begin
                proto_en_q   <= wb_dat_i[`CTRL_PROTO_EN];
                disconnect_q <= wb_dat_i[`CTRL_DISCONNECT];
            end
            if (wb_req) begin
                case (wb_adr_i)
                    `REG_CTRL:   wb_dat_o <= {31'h00000000, proto_en_q};
                    `REG_STATUS: wb_dat_o <= {20'h00000, tap_state, 1'b0, ~sel_eff,
                                              1'b0, status_eff};
                    `REG_FRAMES: wb_dat_o <= {24'h000000, frames_q};
                    default:     wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test-port tracking and frame reception on rising test-clock edges.
    wire              frame_stb;
    wire [9:0]        rx_addr;
    wire [2:0]        rx_pos;
    wire [2:0]        rx_cfg;
    // Frames need quiet states and bypass high.
    wire              proto_allowed = byp_s[5] & proto_en_q & tap_stable;

    tap_state_tracker u_tap (
        .clk_sys (clk_sys),
        .rst_n   (gw_rst_n),
        .step    (tck_rise),
        .tms     (tms_s),
        .state_q (tap_state),
        .stable  (tap_stable)
    );

    shadow_receiver #(
        .FRAME_W (`FRAME_W)
    ) u_rx (
        .clk_sys     (clk_sys),
        .rst_n       (gw_rst_n),
        .bit_stb     (tck_rise),
        .bit_val     (tdi_s),
        .enable      (proto_allowed),
        .frame_stb_q (frame_stb),
        .rx_addr     (rx_addr),
        .rx_pos      (rx_pos),
        .rx_cfg      (rx_cfg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Protocol sequencer: acknowledge, then connect.
    localparam [1:0] SQ_IDLE = 2'h0, SQ_ACK = 2'h1, SQ_CONNECT = 2'h2;
    reg [1:0]            sq_q;
    // The counter marks the last reply bit.
    reg [`ACK_CNT_W-1:0] ack_cnt_q;
    reg [`ACK_BITS-1:0]  ack_sh_q;
    reg [2:0]            cfg_hold_q;

    wire addr_hit  = (rx_addr == addr_s);
    wire pos_hit   = (rx_pos == pos_s);
    // Broadcasts are never acknowledged.
    wire bcast_hit = (rx_addr == `BCAST_ADDR);

    // Bypass low discards any frame in flight; apart from a Wishbone disconnect the status update
    // follows the test clock edges, so a stopped clock freezes the connection.
    always @(posedge clk_sys or negedge gw_rst_n) begin
        if (!gw_rst_n) begin
            sq_q       <= SQ_IDLE;
            ack_cnt_q  <= {`ACK_CNT_W{1'b0}};
            ack_sh_q   <= {`ACK_BITS{1'b0}};
            cfg_hold_q <= `CFG_ALL_OFF;
            status_q   <= `ST_OFF;
            sel_n_q    <= `CFG_ALL_OFF;
            frames_q   <= 8'h00;
        end else if (!byp_s[5]) begin
            sq_q <= SQ_IDLE;
        end else begin
            if (disconnect_q) begin
                status_q <= `ST_OFF;
                sel_n_q  <= `CFG_ALL_OFF;
            end
            case (sq_q)
                SQ_IDLE: begin
                    if (frame_stb && bcast_hit) begin
                        status_q <= `ST_BROADCAST;
                        sel_n_q  <= rx_cfg;
                        frames_q <= frames_q + 8'h01;
                    end else if (frame_stb && addr_hit && pos_hit) begin
                        sq_q       <= SQ_ACK;
                        ack_sh_q   <= `ACK_PATTERN;
                        ack_cnt_q  <= {`ACK_CNT_W{1'b0}};
                        cfg_hold_q <= rx_cfg;
                        frames_q   <= frames_q + 8'h01;
                    end
                end
                SQ_ACK: begin
                    if (tck_fall) begin
                        ack_sh_q  <= {1'b0, ack_sh_q[`ACK_BITS-1:1]};
                        ack_cnt_q <= ack_cnt_q + {{(`ACK_CNT_W-1){1'b0}}, 1'b1};
                        if (ack_cnt_q == `ACK_BITS - 1) begin
                            sq_q <= SQ_CONNECT;
                        end
                    end
                end
                SQ_CONNECT: begin
                    if (tck_rise) begin
                        sq_q     <= SQ_IDLE;
                        sel_n_q  <= cfg_hold_q;
                        status_q <= (cfg_hold_q == `CFG_ALL_OFF) ? `ST_OFF : `ST_ON;
                    end
                end
                default: sq_q <= SQ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective status: bypass pins override everything, then test reset.
    // Test reset is the synchronised copy here.
    always @* begin
        if (!byp_s[5]) begin
            status_eff = trst_n_s ? `ST_BYPASS : `ST_BYPASS_RESET;
            sel_eff    = ~byp_s[2:0];
        end else if (!trst_n_s) begin
            status_eff = `ST_TEST_RESET;
            sel_eff    = 3'h0;
        end else begin
            status_eff = status_q;
            sel_eff    = (status_q == `ST_OFF) ? 3'h0 : ~sel_n_q;
        end
    end

    wire st_active = (status_eff == `ST_BYPASS) || (status_eff == `ST_BYPASS_RESET) ||
                     (status_eff == `ST_BROADCAST) || (status_eff == `ST_ON);
    wire st_drives = (status_eff == `ST_BYPASS) || (status_eff == `ST_BYPASS_RESET) ||
                     (status_eff == `ST_ON);
    wire [2:0] act = st_active ? sel_eff : 3'h0;
    wire       acking = (sq_q == SQ_ACK) && byp_s[5];

    // Selected ports form one chain in port order; a broadcast feeds every
    // selected port straight from the primary input instead.
    // Unselected ports drop out of the chain.
    reg [2:0] chain_in;
    reg       chain_out;
    integer   i;
    always @* begin
        chain_out = tdi_s;
        chain_in  = 3'h0;
        for (i = 0; i < 3; i = i + 1) begin
            chain_in[i] = (status_eff == `ST_BROADCAST) ? tdi_s : chain_out;
            if (act[i]) begin
                chain_out = sdi_s[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs other than the forwarded test clocks, updated only on falling test-clock edges.
    // A stopped test clock freezes them.
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            connect_indicators_n   <= 3'h7;
            primary_data_out       <= 1'b0;
            primary_data_out_oe    <= 1'b0;
            secondary_data_outs    <= 3'h0;
            secondary_data_outs_oe <= 3'h0;
            secondary_test_clocks  <= 3'h0;
        end else begin
            secondary_test_clocks <= {3{tck_s}};
            if (tck_fall) begin
                connect_indicators_n   <= ~act;
                secondary_data_outs    <= chain_in & act;
                secondary_data_outs_oe <= act;
                if (acking) begin
                    primary_data_out    <= ack_sh_q[0];
                    primary_data_out_oe <= 1'b1;
                end else begin
                    primary_data_out    <= chain_out;
                    primary_data_out_oe <= st_drives && (act != 3'h0);
                end
            end
        end
    end
endmodule // scan_gateway

// File: tb/scan_gateway_assertions.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Watches the gateway pins and its register bus from the outside.
module scan_gateway_assertions (
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic [5:0] bypass_select_inputs,
    input wire logic       primary_test_clock,
    input wire logic       primary_test_reset_n,
    input wire logic [2:0] connect_indicators_n,
    input wire logic       primary_data_out,
    input wire logic       primary_data_out_oe,
    input wire logic [2:0] secondary_test_clocks,
    input wire logic [2:0] secondary_data_outs_oe,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o
);
    logic [3:0] hold_q;
    logic [6:0] pins_q;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // Counts steady cycles of the async pins, so checks wait out the synchroniser.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 4'h0;
            pins_q <= 7'h00;
        end else begin
            pins_q <= {primary_test_reset_n, bypass_select_inputs};
            if (pins_q != {primary_test_reset_n, bypass_select_inputs})
                hold_q <= 4'h0;
            else if (hold_q != 4'hf)
                hold_q <= hold_q + 4'h1;
        end
    end
    property p_wb_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack)
        else $error("bus request not answered in the next cycle");
    property p_wb_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_wb_pulse: assert property (p_wb_pulse)
        else $error("bus acknowledge longer than one cycle");
    property p_clk_rise;
        $rose(primary_test_clock) |-> ##[1:4] secondary_test_clocks == 3'h7;
    endproperty
    a_clk_rise: assert property (p_clk_rise)
        else $error("test clock rise not forwarded to all ports");
    property p_clk_fall;
        $fell(primary_test_clock) |-> ##[1:4] secondary_test_clocks == 3'h0;
    endproperty
    a_clk_fall: assert property (p_clk_fall)
        else $error("test clock fall not forwarded to all ports");
    property p_pin_edge;
        disable iff (!rstn || !primary_test_reset_n)
        $changed(connect_indicators_n) || $changed(primary_data_out)
            || $changed(primary_data_out_oe) |-> !secondary_test_clocks[0];
    endproperty
    a_pin_edge: assert property (p_pin_edge)
        else $error("pin output changed outside the low clock phase");
    property p_oe_match;
        disable iff (!rstn || !primary_test_reset_n)
        secondary_data_outs_oe == ~connect_indicators_n;
    endproperty
    a_oe_match: assert property (p_oe_match)
        else $error("secondary drive differs from connect indicators");
    property p_bypass_cfg;
        !bypass_select_inputs[5] && hold_q > 4'h8 && $fell(secondary_test_clocks[0])
            |-> ##[0:3] connect_indicators_n == bypass_select_inputs[2:0]
            && primary_data_out_oe == (bypass_select_inputs[2:0] != 3'h7);
    endproperty
    a_bypass_cfg: assert property (p_bypass_cfg)
        else $error("bypass pins not reflected on the ports");
    property p_test_reset;
        !primary_test_reset_n && bypass_select_inputs[5] && hold_q > 4'h8
            && $fell(secondary_test_clocks[0]) |-> ##[0:3] connect_indicators_n == 3'h7
            && !primary_data_out_oe && secondary_data_outs_oe == 3'h0;
    endproperty
    a_test_reset: assert property (p_test_reset)
        else $error("test reset left a port active");
    // Main scenarios that the bench is expected to reach.
    c_bypass: cover property (!bypass_select_inputs[5] && hold_q > 4'h8);
    c_ack: cover property (wb_ack_o);
    c_connect: cover property ($fell(connect_indicators_n[0]));
endmodule // scan_gateway_assertions

bind scan_gateway scan_gateway_assertions scan_gateway_assertions_inst (
    .clk_sys(clk_sys), .rstn(rstn), .bypass_select_inputs(bypass_select_inputs),
    .primary_test_clock(primary_test_clock), .primary_test_reset_n(primary_test_reset_n),
    .connect_indicators_n(connect_indicators_n), .primary_data_out(primary_data_out),
    .primary_data_out_oe(primary_data_out_oe), .secondary_test_clocks(secondary_test_clocks),
    .secondary_data_outs_oe(secondary_data_outs_oe), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// File: tb/test_master_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Upstream test master on the primary scan bus.
module test_master_model (
    output logic      tck,
    output logic      tdi,
    output logic      tms,
    output logic      trst_n,
    input  wire logic tdo
);
    // Data and mode select idle high as the pull-ups would, test reset starts low; the clock stands still low between frames.
    initial begin
        tck = 1'b0;
        tdi = 1'b1;
        tms = 1'b1;
        trst_n = 1'b0;
    end
    // Shifts n bits MSB first; the reply is read late in the high phase, since the
    // device launches it only after its synchroniser has seen the previous fall.
    task automatic shift(input logic [31:0] bits, input int n, output logic [31:0] got);
        got = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            tdi <= bits[i];
            #160 tck <= 1'b1;
            #150 got = {got[30:0], tdo};
            #10 tck <= 1'b0;
        end
    endtask
    // Test reset is a plain level, applied without regard to the clock.
    task automatic set_reset(input logic v);
        trst_n <= v;
    endtask
endmodule // test_master_model

// File: tb/tb.sv
`timescale 1ns/10ps
`include "scan_gateway_map.vh"
////////////////////////////////////////////////////////////////////////////////
module tb;
    // Address and position are not bit palindromes, so a reversed compare is caught.
    localparam logic [9:0] ADDR = 10'h2c1;
    localparam logic [2:0] POS  = 3'h6;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [5:0]  bypass_select_inputs = 6'h3f;
    logic [2:0]  secondary_data_ins = 3'h0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic        tck, tdi, tms, trst_n, pdo, pdo_oe, wb_ack_o;
    logic [2:0]  con_n, stck, sdo, sdo_oe;
    logic [31:0] wb_dat_o, g;
    logic [7:0]  ack;
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc_cnt = 0;
    scan_gateway scan_gateway_inst (.clk_sys(clk_sys), .rstn(rstn),
        .strap_address_inputs(ADDR), .strap_position_inputs(POS),
        .bypass_select_inputs(bypass_select_inputs), .primary_test_clock(tck),
        .primary_data_in(tdi), .primary_mode_select(tms), .primary_test_reset_n(trst_n),
        .secondary_data_ins(secondary_data_ins), .connect_indicators_n(con_n),
        .primary_data_out(pdo), .primary_data_out_oe(pdo_oe), .secondary_test_clocks(stck),
        .secondary_data_outs(sdo), .secondary_data_outs_oe(sdo_oe), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    test_master_model test_master_model_inst (.tck(tck), .tdi(tdi), .tms(tms),
        .trst_n(trst_n), .tdo(pdo));
    // System clock at 25 MHz.
    always #20 clk_sys = ~clk_sys;
    // Cuts a hang short well beyond the expected run length.
    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic single cycle; the request stands until the acknowledge is sampled.
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        g = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] adr, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, adr, 32'h0);
        chk(g & m, e);
    endtask
    // Clocks n idle bits, then lets the falling-edge updates cross into clk_sys.
    task automatic idle(input int n);
        test_master_model_inst.shift(32'hffffffff, n, g);
        repeat (5) @(posedge clk_sys);
    endtask
    // A full receive window of idle bits first, then the frame and eight reply bits.
    task automatic frame(input logic [9:0] a, input logic [2:0] p, input logic [2:0] c);
        test_master_model_inst.shift(32'hffffffff, 24, g);
        test_master_model_inst.shift({`SYNC_PATTERN, a, p, c, 8'hff}, 32, g);
        ack = {<<{g[7:0]}};
        idle(2);
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk(`REG_STATUS, 32'h7, `ST_TEST_RESET);
        rd_chk(`REG_CTRL, 32'h3, `CTRL_RESET);
        rd_chk(4'hc, 32'hffffffff, 32'h0);
        idle(4);
        chk({con_n, pdo_oe, sdo_oe}, 7'h70);
        test_master_model_inst.set_reset(1'b1);
        frame(ADDR, POS, 3'b110);
        chk(ack, `ACK_PATTERN);
        chk(con_n, 3'b110);
        rd_chk(`REG_STATUS, 32'h7, `ST_ON);
        // Port 0 alone in the chain: input to its output, its return to the primary.
        secondary_data_ins <= 3'b001;
        test_master_model_inst.shift(32'h1, 1, g);
        repeat (5) @(posedge clk_sys);
        chk({sdo[0], pdo_oe, pdo}, 3'b111);
        secondary_data_ins <= 3'b000;
        test_master_model_inst.shift(32'h0, 1, g);
        repeat (5) @(posedge clk_sys);
        chk({sdo[0], pdo_oe, pdo}, 3'b010);
        frame(10'h20d, POS, 3'b000);
        chk(con_n, 3'b110);
        frame(ADDR, 3'h3, 3'b000);
        chk(con_n, 3'b110);
        rd_chk(`REG_FRAMES, 32'hff, 32'h1);
        frame(`BCAST_ADDR, POS, 3'b101);
        chk({con_n, pdo_oe}, 4'b1010);
        rd_chk(`REG_STATUS, 32'h7, `ST_BROADCAST);
        wb(1'b1, `REG_CTRL, 32'h3);
        idle(2);
        chk({con_n, pdo_oe}, 4'b1110);
        rd_chk(`REG_STATUS, 32'h7, `ST_OFF);
        wb(1'b1, `REG_CTRL, 32'h0);
        frame(ADDR, POS, 3'b110);
        chk(con_n, 3'b111);
        // Master bypass low: port 2 only, and frames are ignored.
        bypass_select_inputs <= 6'b011011;
        idle(4);
        chk({con_n, pdo_oe}, 4'b0111);
        rd_chk(`REG_STATUS, 32'h7, `ST_BYPASS);
        frame(ADDR, POS, 3'b110);
        chk(con_n, 3'b011);
        test_master_model_inst.set_reset(1'b0);
        idle(4);
        chk(con_n, 3'b011);
        rd_chk(`REG_STATUS, 32'h7, `ST_BYPASS_RESET);
        bypass_select_inputs <= 6'h3f;
        idle(4);
        chk({con_n, pdo_oe}, 4'b1110);
        rd_chk(`REG_STATUS, 32'h7, `ST_TEST_RESET);
        report_and_stop();
    end
endmodule // tb
